// ==== include/erbl_pkg.sv ====
/*
 * Constants and types of the raw boot locator: boot codes, source codes,
 * slot geometry, image directory word layout and the sector read carrier.
 * Assumes a sector read engine outside that streams 32-bit words.
 */
// Overview of operation
// RL1: Embedded card read raw, no file system
// RL2: Image may start at four 128KB slots
// RL3: Image length never checked or rejected
// RL4: Probe sectors 0, 256, 512, 768 for directory
// RL5: Config header first, image header follows
// RL6: Void config header with cleared flag accepted
// RL7: Four-bit bus during boot, eight after
// RL8: Sample boot pins once after reset
// RL9: Button low bit makes removable card preferred; code has no such order, any pin code but the two boot codes fails
// RL10: Embedded on second port, removable on first
// RL11: Outside override drive gated by board reset
// RL12: Two boot codes give two device orders
// RL13: No directory found, try next device
package erbl_pkg;
    localparam logic [4:0] BOOT_CODE_EMBEDDED = 5'h1C;
    localparam logic [4:0] BOOT_CODE_SPI = 5'h18;
    localparam logic [4:0] BOOT_CODE_RESET = 5'h1C;

    typedef enum logic [2:0] {
        SRC_NONE = 3'b000,
        SRC_EMBEDDED = 3'b001,
        SRC_REMOVABLE = 3'b010,
        SRC_SERIAL = 3'b011,
        SRC_USB = 3'b100,
        SRC_SPI_FLASH = 3'b101
    } erbl_src_type;

    localparam logic PORT_EMBEDDED = 1'b1;
    localparam logic PORT_REMOVABLE = 1'b0;
    localparam logic [1:0] ORDER_LAST = 2'h3;

    localparam logic [1:0] SLOT_LAST = 2'h3;
    localparam logic [31:0] SLOT_SECTORS = 32'h0000_0100;
    localparam logic [31:0] SLOT_BYTES = 32'h0002_0000;
    localparam logic [31:0] SECTOR_BYTES = 32'h0000_0200;

    localparam logic [6:0] WORD_DIR_START = 7'h00;
    localparam logic [6:0] WORD_DIR_SIZE = 7'h01;
    localparam logic [6:0] WORD_DIR_NAME = 7'h05;
    localparam logic [6:0] WORD_SETTINGS = 7'h08;
    localparam logic [6:0] WORD_LAST = 7'h7F;
    localparam logic [31:0] WORD_ERASED = 32'hFFFF_FFFF;
    localparam logic [31:0] WORD_BLANK = 32'h0000_0000;
    localparam int SETTINGS_VALID_BIT = 0;

    typedef struct packed {
        logic valid;
        logic last;
        logic err;
        logic [31:0] data;
    } erbl_rd_type;

    typedef struct packed {
        logic req;
        logic port;
        logic [31:0] sector;
    } erbl_rq_type;
endpackage

// ==== src/erbl_locator.sv ====
/*
 * Boot source selection and raw image locating on the card ports.
 * Assumes a sector read engine on the same clock that takes one request,
 * streams 128 words of the sector, marks the last, or flags an error.
 */
`timescale 1ns/1ps
`default_nettype none
module erbl_locator #(
    parameter logic [31:0] DIR_NAME_TAG = 32'h1234_5678 // Arbitrary value
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [4:0] BOOT_CFG_PINS,
    input wire erbl_pkg::erbl_rd_type RD,
    input wire logic WIDEN_REQ,
    output erbl_pkg::erbl_rq_type RQ,
    output logic BUS_WIDE_8,
    output erbl_pkg::erbl_src_type BOOT_SRC,
    output logic [31:0] IMAGE_OFFSET,
    output logic IMAGE_FOUND,
    output logic BOOT_DONE,
    output logic BOOT_FAIL
);
    import erbl_pkg::*;

    typedef enum logic [2:0] {
        ST_SAMPLE = 3'b000,
        ST_PICK = 3'b001,
        ST_REQ = 3'b010,
        ST_READ = 3'b011,
        ST_CHECK = 3'b100,
        ST_NEXT = 3'b101,
        ST_DONE = 3'b110
    } erbl_state_type;

    function automatic erbl_src_type order_src(input logic [4:0] code,
                                               input logic [1:0] idx);
        erbl_src_type s;
        s = SRC_NONE;
        if (code == BOOT_CODE_EMBEDDED) begin
            case (idx)
                2'h0: s = SRC_EMBEDDED;
                2'h1: s = SRC_REMOVABLE;
                2'h2: s = SRC_SERIAL;
                default: s = SRC_USB;
            endcase
        end else if (code == BOOT_CODE_SPI) begin
            case (idx)
                2'h0: s = SRC_SPI_FLASH;
                2'h1: s = SRC_REMOVABLE;
                2'h2: s = SRC_USB;
                default: s = SRC_SERIAL;
            endcase
        end
        return s;
    endfunction

    logic [4:0] pins_m_q;
    logic [4:0] pins_s_q;
    logic [4:0] code_q;
    erbl_state_type state_q;
    logic [1:0] order_q;
    logic [1:0] slot_q;
    logic [6:0] word_q;
    logic start_ok_q;
    logic name_ok_q;
    logic rd_err_q;
    erbl_rq_type rq_q;
    logic wide_q;
    erbl_src_type src_q;
    logic [31:0] offset_q;
    logic found_q;
    logic done_q;
    logic fail_q;

    wire erbl_src_type cur_src = order_src(code_q, order_q);
    wire cur_is_card = (cur_src == SRC_EMBEDDED) ||
                       (cur_src == SRC_REMOVABLE);
    wire cur_port = (cur_src == SRC_EMBEDDED) ? PORT_EMBEDDED
                                              : PORT_REMOVABLE; // see RL10
    // Raw sector number, slot times 256; no file system walk. see RL1 RL4
    wire [31:0] probe_sector = SLOT_SECTORS * {30'h0, slot_q};
    wire [31:0] slot_offset = SLOT_BYTES * {30'h0, slot_q}; // see RL2
    wire word_start_bad = (RD.data == WORD_BLANK) ||
                          (RD.data == WORD_ERASED);
    // Directory first entry must point at a config header. see RL5
    wire dir_valid = start_ok_q && name_ok_q && !rd_err_q;
    wire last_slot = (slot_q == SLOT_LAST);
    wire last_order = (order_q == ORDER_LAST);

    always_ff @(posedge CLK) begin
        pins_m_q <= BOOT_CFG_PINS;
        pins_s_q <= pins_m_q;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_q <= ST_SAMPLE;
            code_q <= BOOT_CODE_RESET;
            order_q <= 2'h0;
            slot_q <= 2'h0;
            word_q <= 7'h00;
            start_ok_q <= 1'b0;
            name_ok_q <= 1'b0;
            rd_err_q <= 1'b0;
            rq_q <= '0;
            wide_q <= 1'b0;
            src_q <= SRC_NONE;
            offset_q <= 32'h0000_0000;
            found_q <= 1'b0;
            done_q <= 1'b0;
            fail_q <= 1'b0;
        end else begin
            rq_q.req <= 1'b0;
            case (state_q)
                ST_SAMPLE: begin
                    // Captured once; later pin changes are ignored.
                    // see RL8 RL9 RL11
                    code_q <= pins_s_q;
                    state_q <= ST_PICK;
                end
                ST_PICK: begin
                    slot_q <= 2'h0;
                    src_q <= cur_src; // see RL12
                    if (cur_src == SRC_NONE) begin
                        fail_q <= 1'b1;
                        done_q <= 1'b1;
                        state_q <= ST_DONE;
                    end else if (cur_is_card) begin
                        state_q <= ST_REQ;
                    end else begin
                        // Non-card loaders live elsewhere; hand off.
                        done_q <= 1'b1;
                        state_q <= ST_DONE;
                    end
                end
                ST_REQ: begin
                    rq_q.req <= 1'b1;
                    rq_q.port <= cur_port;
                    rq_q.sector <= probe_sector; // see RL4
                    word_q <= 7'h00;
                    start_ok_q <= 1'b0;
                    name_ok_q <= 1'b0;
                    rd_err_q <= 1'b0;
                    state_q <= ST_READ;
                end
                ST_READ: begin
                    if (RD.valid) begin
                        word_q <= word_q + 7'h01;
                        if (word_q == WORD_DIR_START) begin
                            start_ok_q <= !word_start_bad;
                        end
                        if (word_q == WORD_DIR_NAME) begin
                            name_ok_q <= (RD.data == DIR_NAME_TAG);
                        end
                        // Settings valid flag may be either value, so a
                        // void header still passes. see RL6
                        if (RD.err) begin
                            rd_err_q <= 1'b1;
                        end
                        if (RD.last || RD.err || word_q == WORD_LAST) begin
                            state_q <= ST_CHECK;
                        end
                    end
                end
                ST_CHECK: begin
                    if (dir_valid) begin
                        // Size word is not compared against the slot
                        // span; overlap into the next slot is allowed.
                        // see RL3
                        offset_q <= slot_offset;
                        found_q <= 1'b1;
                        done_q <= 1'b1;
                        state_q <= ST_DONE;
                    end else if (last_slot) begin
                        state_q <= ST_NEXT; // see RL13
                    end else begin
                        slot_q <= slot_q + 2'h1;
                        state_q <= ST_REQ;
                    end
                end
                ST_NEXT: begin
                    if (last_order) begin
                        src_q <= SRC_NONE;
                        fail_q <= 1'b1;
                        done_q <= 1'b1;
                        state_q <= ST_DONE;
                    end else begin
                        order_q <= order_q + 2'h1;
                        state_q <= ST_PICK;
                    end
                end
                ST_DONE: begin
                    // Eight-bit bus only once boot has finished. see RL7
                    if (WIDEN_REQ && found_q) begin
                        wide_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_SAMPLE;
                end
            endcase
        end
    end

    assign RQ = rq_q;
    assign BUS_WIDE_8 = wide_q;
    assign BOOT_SRC = src_q;
    assign IMAGE_OFFSET = offset_q;
    assign IMAGE_FOUND = found_q;
    assign BOOT_DONE = done_q;
    assign BOOT_FAIL = fail_q;
endmodule
`default_nettype wire

// ==== tb/erbl_monitor.sv ====
/* Port checker of the raw boot locator.
   Assumes it is bound to every erbl_locator instance. */
`timescale 1ns/1ps
`default_nettype none
module erbl_monitor (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [4:0] BOOT_CFG_PINS,
    input wire logic WIDEN_REQ,
    input wire erbl_pkg::erbl_rq_type RQ,
    input wire logic BUS_WIDE_8,
    input wire erbl_pkg::erbl_src_type BOOT_SRC,
    input wire logic [31:0] IMAGE_OFFSET,
    input wire logic IMAGE_FOUND,
    input wire logic BOOT_DONE,
    input wire logic BOOT_FAIL
);
    import erbl_pkg::*;
    logic [31:0] sec_q;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sec_q <= 32'h0;
        end else if (RQ.req) begin
            sec_q <= RQ.sector;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_found;
        $rose(IMAGE_FOUND);
    endsequence
    a_req_pulse: assert property (RQ.req |=> !RQ.req [*2])
        else $error("request not a lone pulse");
    a_raw_sector: assert property (RQ.req |-> RQ.sector < 32'h400 &&
        RQ.sector[7:0] == 8'h00) else $error("sector off the probe set");
    a_port_map: assert property (RQ.req |->
        RQ.port == (BOOT_SRC == SRC_EMBEDDED)) else $error("wrong card port");
    a_slot_offset: assert property (s_found |->
        IMAGE_OFFSET == {sec_q[22:0], 9'h000}) else $error("offset off slot");
    a_narrow_boot: assert property (!IMAGE_FOUND |-> !BUS_WIDE_8)
        else $error("wide bus before image found");
    a_widen_take: assert property (IMAGE_FOUND && BOOT_DONE && WIDEN_REQ |=>
        BUS_WIDE_8) else $error("widen request lost");
    a_first_pick: assert property ($past(BOOT_SRC) == SRC_NONE &&
        BOOT_SRC != SRC_NONE |-> BOOT_SRC == (BOOT_CFG_PINS == BOOT_CODE_SPI ?
        SRC_SPI_FLASH : SRC_EMBEDDED)) else $error("wrong first source");
    a_src_held: assert property (BOOT_DONE |=> BOOT_DONE && $stable(BOOT_SRC))
        else $error("source moved after done");
    a_fail_clean: assert property (BOOT_FAIL |-> BOOT_DONE &&
        !IMAGE_FOUND && BOOT_SRC == SRC_NONE) else $error("fail with a source");
endmodule
bind erbl_locator erbl_monitor u_mon (
    .CLK(CLK),
    .RST_N(RST_N),
    .BOOT_CFG_PINS(BOOT_CFG_PINS),
    .WIDEN_REQ(WIDEN_REQ),
    .RQ(RQ),
    .BUS_WIDE_8(BUS_WIDE_8),
    .BOOT_SRC(BOOT_SRC),
    .IMAGE_OFFSET(IMAGE_OFFSET),
    .IMAGE_FOUND(IMAGE_FOUND),
    .BOOT_DONE(BOOT_DONE),
    .BOOT_FAIL(BOOT_FAIL)
);
`default_nettype wire

// ==== tb/erbl_card_model.sv ====
/* Sector read engine with one card on each port.
   Assumes one outstanding request, as the locator keeps. */
`timescale 1ns/1ps
`default_nettype none
module erbl_card_model #(
    parameter logic [31:0] TAG = 32'h0
) (
    input wire logic CLK,
    input wire erbl_pkg::erbl_rq_type RQ,
    input wire logic [2:0] GOOD_EMB,
    input wire logic [2:0] GOOD_REM,
    output var erbl_pkg::erbl_rd_type RD
);
    import erbl_pkg::*;
    int n = -1;
    int stall = 0;
    logic [31:0] sec = 32'h0;
    logic [31:0] junk = 32'h0;
    logic prt = 1'b0;
    logic hit;
    logic cut;
    // Low bits pick the good slot; bit 2 makes that read fail mid-sector
    assign hit = (prt ? GOOD_EMB[1:0] : GOOD_REM[1:0]) == sec[9:8];
    assign cut = hit && (prt ? GOOD_EMB[2] : GOOD_REM[2]);
    always @(posedge CLK) begin
        junk <= junk + 32'h9E37;
        RD <= '0;
        RD.data <= ~junk; // Idle data keeps moving
        if (RQ.req) begin
            sec <= RQ.sector;
            prt <= RQ.port;
            n <= 0;
            stall <= $urandom_range(0, 3);
        end else if (n >= 0 && stall > 0) begin
            stall <= stall - 1;
        end else if (n >= 0) begin
            RD.valid <= 1'b1;
            RD.last <= n == 127;
            RD.err <= cut && n == 6; // Failed read hides a good name
            RD.data <= n == 0 ? (hit ? 32'h0000_0040 : WORD_ERASED)
                : n == 1 ? 32'h0003_0000 // Longer than a slot
                : n == 5 ? (hit ? TAG : ~TAG)
                : n == 8 ? WORD_BLANK : junk; // Void settings
            n <= (n == 127 || (cut && n == 6)) ? -1 : n + 1;
        end
    end
endmodule
`default_nettype wire

// ==== tb/emmc_raw_boot_locator_bench.sv ====
/* Self-checking bench of the raw boot locator against a card model.
   Assumes the locator package and a 250 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module emmc_raw_boot_locator_bench;
    import erbl_pkg::*;
    localparam logic [31:0] TAG = 32'h5A5A_0F0F; // Arbitrary value
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] pins = 5'h00;
    logic widen = 1'b0;
    logic [2:0] good_emb = 3'h4;
    logic [2:0] good_rem = 3'h4;
    erbl_rd_type rd;
    erbl_rq_type rq;
    erbl_src_type src;
    logic wide, found, done, fail;
    logic [31:0] offset;
    int n_mismatch = 0;
    int n_tests = 0;
    logic [32:0] exp_q[$];
    always #2 clk = ~clk;
    erbl_locator #(.DIR_NAME_TAG(TAG)) u_dut (.CLK(clk), .RST_N(rst_n),
        .BOOT_CFG_PINS(pins), .RD(rd), .WIDEN_REQ(widen), .RQ(rq),
        .BUS_WIDE_8(wide), .BOOT_SRC(src), .IMAGE_OFFSET(offset),
        .IMAGE_FOUND(found), .BOOT_DONE(done), .BOOT_FAIL(fail));
    erbl_card_model #(.TAG(TAG)) u_card (.CLK(clk), .RQ(rq),
        .GOOD_EMB(good_emb), .GOOD_REM(good_rem), .RD(rd));
    task automatic cmp_val(input string what, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic run_one(input logic [4:0] code, input logic [2:0] ge, gr,
        input logic wd);
        logic [2:0] es;
        logic ef;
        logic [31:0] eo;
        logic [32:0] e;
        int n;
        exp_q = {};
        ef = 1'b0;
        eo = 32'h0;
        es = code == BOOT_CODE_SPI ? SRC_SPI_FLASH : SRC_NONE;
        if (code == BOOT_CODE_EMBEDDED) begin
            es = SRC_SERIAL; // Both cards empty
            for (int c = 0; c < 2 && !ef; c++) begin
                for (int s = 0; s < 4 && !ef; s++) begin
                    exp_q.push_back({c == 0, 32'(s * 256)});
                    ef = (c ? gr : ge) == 3'(s);
                    eo = 32'(s) * SLOT_BYTES;
                end
                if (ef) es = c ? SRC_REMOVABLE : SRC_EMBEDDED;
            end
        end
        @(posedge clk);
        rst_n <= 1'b0;
        pins <= code;
        widen <= wd;
        good_emb <= ge;
        good_rem <= gr;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (n = 0; done !== 1'b1 && n < 3000; n++) begin
            @(posedge clk);
            if (n == 5) pins <= ~code; // Override lifted
            #1;
            if (rq.req === 1'b1) begin
                e = exp_q.size() > 0 ? exp_q.pop_front() : '1;
                cmp_val("sector", e[31:0], rq.sector);
                cmp_val("port", 32'(e[32]), 32'(rq.port));
            end
        end
        if (n >= 3000) n_mismatch++;
        repeat (2) @(posedge clk);
        #1;
        cmp_val("source", 32'(es), 32'(src));
        cmp_val("found", 32'(ef), 32'(found));
        if (ef) cmp_val("offset", eo, offset);
        cmp_val("fail", 32'(es == SRC_NONE), 32'(fail));
        cmp_val("wide", 32'(wd & ef), 32'(wide));
        cmp_val("left", 32'h0, 32'(exp_q.size()));
    endtask
    initial begin
        void'($urandom(44));
        for (int i = 0; i < 15; i++) begin
            run_one(i % 3 == 2 ? 5'($urandom_range(0, 31)) :
                i % 3 == 1 ? BOOT_CODE_SPI : BOOT_CODE_EMBEDDED,
                i % 3 == 0 && i < 6 ? 3'h4 : 3'($urandom_range(0, 7)),
                i == 0 ? 3'h3 : i == 3 ? 3'h4 : 3'($urandom_range(0, 7)),
                1'($urandom));
        end
        close_out();
    end
    initial begin
        // Fifteen runs of at most eight sectors each need well under this
        #200000;
        n_mismatch++;
        close_out();
    end
endmodule
`default_nettype wire
